/* File: hw/aot_engine.sv */
// Analog output timing engine with AXI4-Lite register slave
`timescale 1ns/1ps
`default_nettype none
module aot_engine
  import aot_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic SRST,
  input wire logic CE,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic [NPFI-1:0] PFI_IN,
  input wire logic [NSIL-1:0] SIL_IN,
  input wire logic [NINT-1:0] INT_SIG,
  output logic START_PIN_O,
  output logic START_PIN_OE,
  output logic SAMP_PIN_O,
  output logic SAMP_PIN_OE,
  output logic UPDATE
);
  aot_st_t st_r;
  aot_st_t n;
  logic [LW-1:0] lv;
  logic [LW-1:0] lp;
  logic fast_tick;
  logic root_tick;
  logic slow_tick;
  logic tb_tick;
  logic start_ev;
  logic paused;
  logic cand;
  logic acc;
  logic wr_fire;
  logic [ADDR_W-1:0] wa;
  logic [ADDR_W-1:0] ra;
  logic cmd_arm;
  logic cmd_start;
  logic cmd_stop;

  function automatic logic pick(input logic [LW-1:0] v, input logic [4:0] s);
    pick = (int'(s) < LW) ? v[s] : 1'b0;
  endfunction : pick

  function automatic logic edg(input logic c, input logic p, input logic f);
    edg = f ? (p & ~c) : (c & ~p);
  endfunction : edg

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = d[i*8 +: 8];
      end
    end
    wmerge = r;
  endfunction : wmerge

  always_comb begin
    n = st_r;
    // Three stages; a change counts once stages two and three agree
    n.s1 = {SIL_IN, PFI_IN};
    n.s2 = st_r.s1;
    n.s3 = st_r.s2;
    n.filt = (st_r.s2 & st_r.s3) | (st_r.filt & (st_r.s2 ^ st_r.s3));
    n.prev = st_r.filt;
    n.int_prev = INT_SIG;
    // Routable lines: programmable lines, lines 0-6, on-chip signals
    lv = {INT_SIG, st_r.filt[NPFI+6:0]};
    lp = {st_r.int_prev, st_r.prev[NPFI+6:0]};

    // Root timebase: fast internal tick or line 7; never reaches a pin
    fast_tick = (st_r.fast_cnt == FAST_DIV_M1);
    n.fast_cnt = fast_tick ? 8'h00 : st_r.fast_cnt + 8'h01;
    root_tick = st_r.mode.root_sil7 ? (st_r.filt[NPFI+7] & ~st_r.prev[NPFI+7])
                                    : fast_tick;
    slow_tick = root_tick && (st_r.slow_cnt == SLOW_DIV_M1);
    if (root_tick) begin
      n.slow_cnt = slow_tick ? 8'h00 : st_r.slow_cnt + 8'h01;
    end
    if (st_r.cfg.tb_ext) begin
      tb_tick = edg(pick(lv, st_r.cfg.tb_sel), pick(lp, st_r.cfg.tb_sel),
                    st_r.cfg.tb_edge);
    end else begin
      tb_tick = st_r.cfg.tb_slow ? slow_tick : root_tick;
    end

    // Register slave, one write and one read at a time
    wa = {st_r.awaddr[ADDR_W-1:2], 2'h0};
    ra = {S_AXI_ARADDR[ADDR_W-1:2], 2'h0};
    if (S_AXI_AWVALID && st_r.aw_rdy) begin
      n.aw_rdy = 1'b0;
      n.aw_got = 1'b1;
      n.awaddr = S_AXI_AWADDR;
    end
    if (S_AXI_WVALID && st_r.w_rdy) begin
      n.w_rdy = 1'b0;
      n.w_got = 1'b1;
      n.wdata = S_AXI_WDATA;
      n.wstrb = S_AXI_WSTRB;
    end
    wr_fire = st_r.aw_got && st_r.w_got && !st_r.bvalid;
    cmd_arm = 1'b0;
    cmd_start = 1'b0;
    cmd_stop = 1'b0;
    if (wr_fire) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.bvalid = 1'b1;
      n.bresp = RESP_OKAY;
      case (wa)
        ADDR_CTRL: begin
          cmd_arm = st_r.wstrb[0] && st_r.wdata[CTRL_ARM];
          cmd_start = st_r.wstrb[0] && st_r.wdata[CTRL_START];
          cmd_stop = st_r.wstrb[0] && st_r.wdata[CTRL_STOP];
          if (st_r.wstrb[0]) begin
            n.mode = aot_mode_t'(st_r.wdata[CTRL_MODE_LSB +: 4]);
          end
        end
        ADDR_CFG: n.cfg = aot_cfg_t'(wmerge(32'(st_r.cfg), st_r.wdata, st_r.wstrb));
        ADDR_DIV: n.div = wmerge(st_r.div, st_r.wdata, st_r.wstrb);
        ADDR_DELAY: n.delay = wmerge(st_r.delay, st_r.wdata, st_r.wstrb);
        ADDR_COUNT: n.count = wmerge(st_r.count, st_r.wdata, st_r.wstrb);
        ADDR_STATUS, ADDR_DONE: n.bresp = RESP_OKAY;
        default: n.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && S_AXI_BREADY) begin
      n.bvalid = 1'b0;
      n.aw_rdy = 1'b1;
      n.w_rdy = 1'b1;
    end
    if (S_AXI_ARVALID && st_r.ar_rdy) begin
      n.ar_rdy = 1'b0;
      n.rvalid = 1'b1;
      n.rresp = RESP_OKAY;
      case (ra)
        ADDR_CTRL: n.rdata = {25'h0, st_r.mode, 3'h0};
        ADDR_CFG: n.rdata = 32'(st_r.cfg);
        ADDR_DIV: n.rdata = st_r.div;
        ADDR_DELAY: n.rdata = st_r.delay;
        ADDR_COUNT: n.rdata = st_r.count;
        ADDR_STATUS: n.rdata = {27'h0, st_r.samp_o, paused, st_r.done, st_r.state};
        ADDR_DONE: n.rdata = st_r.done_cnt;
        default: begin
          n.rdata = 32'h0000_0000;
          n.rresp = RESP_SLVERR;
        end
      endcase
    end
    if (st_r.rvalid && S_AXI_RREADY) begin
      n.rvalid = 1'b0;
      n.ar_rdy = 1'b1;
    end

    // Start: hardware edge when enabled, else the software command
    if (st_r.cfg.start_en) begin
      start_ev = edg(pick(lv, st_r.cfg.start_sel), pick(lp, st_r.cfg.start_sel),
                     st_r.cfg.start_edge);
    end else begin
      start_ev = cmd_start;
    end
    // Level pause, polarity selected; there is no pin for it
    paused = st_r.cfg.pause_en &&
             (pick(lv, st_r.cfg.pause_sel) == st_r.cfg.pause_pol);

    cand = 1'b0;
    case (st_r.state)
      ST_IDLE: begin
        if (cmd_arm) begin
          n.state = ST_ARMED;
          n.done = 1'b0;
          n.done_cnt = 32'h0000_0000;
        end
      end
      ST_ARMED: begin
        if (start_ev) begin
          if (st_r.cfg.samp_ext) begin
            n.state = ST_RUN;
          end else begin
            n.state = ST_DELAY;
            n.dly_cnt = st_r.delay;
          end
        end
      end
      ST_DELAY: begin
        if (tb_tick) begin
          if (st_r.dly_cnt <= 32'h0000_0001) begin
            cand = 1'b1;
            n.state = ST_RUN;
            n.div_cnt = st_r.div;
          end else begin
            n.dly_cnt = st_r.dly_cnt - 32'h0000_0001;
          end
        end
      end
      ST_RUN: begin
        if (st_r.cfg.samp_ext) begin
          cand = edg(pick(lv, st_r.cfg.samp_sel), pick(lp, st_r.cfg.samp_sel),
                     st_r.cfg.samp_edge);
        end else if (tb_tick) begin
          if (st_r.div_cnt <= 32'h0000_0001) begin
            cand = 1'b1;
            n.div_cnt = st_r.div;
          end else begin
            n.div_cnt = st_r.div_cnt - 32'h0000_0001;
          end
        end
      end
      default: n.state = ST_IDLE;
    endcase

    // Pause is judged only when a sample would begin, so a running one completes
    acc = cand && !paused;
    n.update = acc;
    if (acc) begin
      n.spw = PULSE_CYC;
      n.done_cnt = st_r.done_cnt + 32'h0000_0001;
      if (st_r.mode.finite && (st_r.done_cnt + 32'h0000_0001 == st_r.count)) begin
        n.state = ST_IDLE;
        n.done = 1'b1;
      end
    end else if (st_r.spw != 8'h00) begin
      n.spw = st_r.spw - 8'h01;
    end
    if (cmd_stop) begin
      n.state = ST_IDLE;
    end
    n.samp_o = (n.spw != 8'h00);

    // Start echo follows every internal start, whatever its source
    if (start_ev) begin
      n.tpw = PULSE_CYC;
    end else if (st_r.tpw != 8'h00) begin
      n.tpw = st_r.tpw - 8'h01;
    end
    n.start_o = (n.tpw != 8'h00);
  end

  always_ff @(posedge CORE_CLK) begin
    if (SRST) begin
      st_r <= '0;
      // Chains start at the idle level, so no false edge follows reset
      st_r.s1 <= LINE_IDLE;
      st_r.s2 <= LINE_IDLE;
      st_r.s3 <= LINE_IDLE;
      st_r.filt <= LINE_IDLE;
      st_r.prev <= LINE_IDLE;
      st_r.div <= DIV_RST;
      st_r.delay <= DELAY_RST;
      st_r.count <= COUNT_RST;
      st_r.aw_rdy <= 1'b1;
      st_r.w_rdy <= 1'b1;
      st_r.ar_rdy <= 1'b1;
    end else if (CE) begin
      st_r <= n;
    end
  end

  assign S_AXI_AWREADY = st_r.aw_rdy;
  assign S_AXI_WREADY = st_r.w_rdy;
  assign S_AXI_BVALID = st_r.bvalid;
  assign S_AXI_BRESP = st_r.bresp;
  assign S_AXI_ARREADY = st_r.ar_rdy;
  assign S_AXI_RVALID = st_r.rvalid;
  assign S_AXI_RDATA = st_r.rdata;
  assign S_AXI_RRESP = st_r.rresp;
  assign START_PIN_O = st_r.start_o;
  assign START_PIN_OE = st_r.mode.start_pin_out;
  assign SAMP_PIN_O = st_r.samp_o;
  assign SAMP_PIN_OE = st_r.mode.samp_pin_out;
  assign UPDATE = st_r.update;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (SRST);

  update_cause_a: assert property (UPDATE && $past(CE) |->
                                   $past(st_r.state) inside {ST_DELAY, ST_RUN})
    else $error("update outside an armed and started generation");
  pause_mask_a: assert property (CE && cand && paused |=> !UPDATE)
    else $error("update issued while paused");
  pulse_hold_a: assert property ($rose(SAMP_PIN_O) |-> SAMP_PIN_O[*5])
    else $error("sample pulse cut short");
  reset_pins_a: assert property ($fell(SRST) |-> !START_PIN_OE && !SAMP_PIN_OE)
    else $error("pin driven right after reset");
  start_echo_a: assert property (CE && start_ev |=> START_PIN_O ##1 START_PIN_O)
    else $error("start echo pulse missing");
  first_delay_a: assert property (CE && st_r.state == ST_DELAY && tb_tick && !paused &&
                                  st_r.dly_cnt == 32'h1 |=> UPDATE)
    else $error("first sample not issued at end of delay");
  finite_stop_a: assert property (CE && acc && !cmd_stop && st_r.mode.finite &&
                                  st_r.done_cnt + 32'h1 == st_r.count
                                  |=> st_r.state == ST_IDLE && st_r.done)
    else $error("finite generation did not stop");
  div_reload_a: assert property (CE && acc && st_r.state == ST_RUN && !st_r.cfg.samp_ext &&
                                 !wr_fire |=> st_r.div_cnt == $past(st_r.div))
    else $error("divider not reloaded after sample");
  sw_start_a: assert property (CE && st_r.state == ST_ARMED && !st_r.cfg.start_en &&
                               cmd_start && !cmd_stop |=> st_r.state != ST_ARMED)
    else $error("software start ignored");
  resp_hold_a: assert property (S_AXI_BVALID && !S_AXI_BREADY |=> S_AXI_BVALID)
    else $error("write response dropped before taken");
  // Bus answers, sync chain and generation steps
  rd_answer_a: assert property (CE && S_AXI_ARVALID && S_AXI_ARREADY |=> S_AXI_RVALID)
    else $error("read answer late");
  sync_agree_a: assert property (CE && st_r.s2 == st_r.s3 |=> st_r.filt == $past(st_r.s3))
    else $error("line filter did not follow agreed stages");
  stop_idle_a: assert property (CE && cmd_stop |=> st_r.state == ST_IDLE)
    else $error("software stop ignored");
  arm_clear_a: assert property (CE && st_r.state == ST_IDLE && cmd_arm && !cmd_stop
                                |=> st_r.state == ST_ARMED && !st_r.done &&
                                st_r.done_cnt == 32'h0000_0000)
    else $error("arm did not clear the sample count");
  delay_load_a: assert property (CE && st_r.state == ST_ARMED && start_ev &&
                                 !st_r.cfg.samp_ext && !cmd_stop
                                 |=> st_r.state == ST_DELAY &&
                                 st_r.dly_cnt == $past(st_r.delay))
    else $error("start did not load the first sample delay");
  idle_quiet_a: assert property (CE && st_r.state inside {ST_IDLE, ST_ARMED} |=> !UPDATE)
    else $error("update before generation started");
  samp_echo_a: assert property (CE && acc |=> SAMP_PIN_O && UPDATE)
    else $error("accepted sample not echoed");
  samp_rise_a: assert property ($rose(SAMP_PIN_O) |-> UPDATE)
    else $error("sample pin pulse without update");
  start_rise_a: assert property ($rose(START_PIN_O) |-> $past(start_ev))
    else $error("start pin pulse without start");
  root_line_a: assert property (st_r.mode.root_sil7 && !st_r.cfg.tb_ext &&
                                !st_r.cfg.tb_slow |-> tb_tick == (st_r.filt[NPFI+7] &&
                                !st_r.prev[NPFI+7]))
    else $error("timebase not taken from line 7");

  run_seen_c: cover property (st_r.state == ST_DELAY ##[1:300] UPDATE);
  pause_seen_c: cover property (CE && cand && paused);
  finite_done_c: cover property ($rose(st_r.done));
  ext_run_c: cover property (CE && st_r.state == ST_RUN && st_r.cfg.samp_ext && acc);
  tb_ext_c: cover property (CE && st_r.cfg.tb_ext && tb_tick && st_r.state == ST_RUN);
endmodule : aot_engine
`default_nettype wire

/* File: hw/aot_pkg.sv */
// Package for the analog output timing engine: constants, register map and state types
package aot_pkg;
  localparam int NPFI = 10;
  localparam int NSIL = 8;
  localparam int NINT = 4;
  localparam int NEXT = NPFI + NSIL;
  localparam int LW = NPFI + 7 + NINT;
  localparam int ADDR_W = 8;
  localparam int CORE_HZ = 100_000_000;
  localparam int FAST_TB_HZ = 20_000_000;
  localparam int SLOW_TB_HZ = 100_000;
  localparam int PULSE_NS = 50;
  localparam logic [7:0] FAST_DIV_M1 = 8'(CORE_HZ / FAST_TB_HZ - 1);
  localparam logic [7:0] SLOW_DIV_M1 = 8'(FAST_TB_HZ / SLOW_TB_HZ - 1);
  localparam logic [7:0] PULSE_CYC = 8'((PULSE_NS * (CORE_HZ / 1_000_000) + 999) / 1000);
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_CFG = 8'h04;
  localparam logic [7:0] ADDR_DIV = 8'h08;
  localparam logic [7:0] ADDR_DELAY = 8'h0C;
  localparam logic [7:0] ADDR_COUNT = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_DONE = 8'h18;
  localparam int CTRL_ARM = 0;
  localparam int CTRL_START = 1;
  localparam int CTRL_STOP = 2;
  localparam int CTRL_MODE_LSB = 3;
  localparam logic [31:0] DIV_RST = 32'h0000_0014;
  localparam logic [31:0] DELAY_RST = 32'h0000_0002;
  localparam logic [31:0] COUNT_RST = 32'h0000_0000;
  // Programmable pins idle high on their pull-ups, other lines low
  localparam logic [NEXT-1:0] LINE_IDLE = {{NSIL{1'h0}}, {NPFI{1'h1}}};
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_ARMED, ST_DELAY, ST_RUN} aot_state_t;

  typedef struct packed {
    logic [2:0] rsvd;
    logic tb_slow;
    logic tb_edge;
    logic tb_ext;
    logic [4:0] tb_sel;
    logic samp_edge;
    logic samp_ext;
    logic [4:0] samp_sel;
    logic pause_pol;
    logic pause_en;
    logic [4:0] pause_sel;
    logic start_edge;
    logic start_en;
    logic [4:0] start_sel;
  } aot_cfg_t;

  typedef struct packed {
    logic samp_pin_out;
    logic start_pin_out;
    logic root_sil7;
    logic finite;
  } aot_mode_t;

  typedef struct packed {
    logic [NEXT-1:0] s1;
    logic [NEXT-1:0] s2;
    logic [NEXT-1:0] s3;
    logic [NEXT-1:0] filt;
    logic [NEXT-1:0] prev;
    logic [NINT-1:0] int_prev;
    logic [7:0] fast_cnt;
    logic [7:0] slow_cnt;
    aot_cfg_t cfg;
    aot_mode_t mode;
    logic [31:0] div;
    logic [31:0] delay;
    logic [31:0] count;
    logic [31:0] done_cnt;
    logic [31:0] dly_cnt;
    logic [31:0] div_cnt;
    aot_state_t state;
    logic done;
    logic update;
    logic [7:0] spw;
    logic [7:0] tpw;
    logic samp_o;
    logic start_o;
    logic aw_rdy;
    logic w_rdy;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } aot_st_t;
endpackage : aot_pkg

/* File: testbench/aot_src_model.sv */
// Far-side trigger and clock source model
`timescale 1ns/1ps
`default_nettype none
module aot_src_model
  import aot_pkg::*;
(
  input wire logic CORE_CLK,
  output logic [NPFI-1:0] PFI_IN,
  output logic [NSIL-1:0] SIL_IN,
  output logic [NINT-1:0] INT_SIG
);
  // Idle: pulled-up pins high, other lines low
  logic [21:0] ln = {4'h0, 8'h00, 10'h3FF};
  assign {INT_SIG, SIL_IN, PFI_IN} = ln;
  // Flat index: 0-9 pins, 10-17 lines 0-7, 18-21 internal
  task automatic pulse(input int i, input int n);
    @(posedge CORE_CLK) ln[i] <= ~ln[i];
    repeat (n) @(posedge CORE_CLK);
    ln[i] <= ~ln[i];
  endtask : pulse
  task automatic hold(input int i, input logic v);
    @(posedge CORE_CLK) ln[i] <= v;
  endtask : hold
endmodule : aot_src_model
`default_nettype wire

/* File: testbench/test_aot_engine.sv */
// Self-checking bench for the analog output timing engine
`timescale 1ns/1ps
`default_nettype none
module test_aot_engine;
  import aot_pkg::*;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic ce = 1'b1;
  logic clr_req = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic arv = 1'b0;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic awr, w_rdy, bv, arr, rv, st_o, st_oe, sp_o, sp_oe, upd;
  logic [1:0] br, rr;
  logic [31:0] rd;
  logic [NPFI-1:0] programmable_function_line, pfi_w;
  logic [NSIL-1:0] sil;
  logic [NINT-1:0] isig;
  int fail_count = 0;
  int total_checks = 0;
  int upd_cnt = 0;
  int gap = 0;
  int last = 0;
  int cyc = 0;
  int spw = 0;
  int stw = 0;
  int tf = 0;
  aot_cfg_t cfg;
  // Shared pins: the driving party wins
  assign pfi_w = {programmable_function_line[9:7], st_oe ? st_o : programmable_function_line[6], sp_oe ? sp_o : programmable_function_line[5], programmable_function_line[4:0]};

  initial begin
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cyc <= cyc + 1;
    // Counters have this one driver; the test only requests a clear
    if (clr_req) begin
      upd_cnt <= 0;
      spw <= 0;
      stw <= 0;
    end else begin
      if (upd === 1'b1) begin
        upd_cnt <= upd_cnt + 1;
        gap <= cyc - last;
        last <= cyc;
        if (upd_cnt == 0) tf <= cyc;
      end
      if (sp_o === 1'b1) spw <= spw + 1;
      if (st_o === 1'b1) stw <= stw + 1;
    end
  end

  aot_engine u_aot_engine (
    .CORE_CLK(clk), .SRST(srst), .CE(ce),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(w_rdy), .S_AXI_WDATA(wd), .S_AXI_WSTRB(4'hF),
    .S_AXI_BVALID(bv), .S_AXI_BREADY(1'b1), .S_AXI_BRESP(br),
    .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_ARADDR(ara),
    .S_AXI_RVALID(rv), .S_AXI_RREADY(1'b1), .S_AXI_RDATA(rd), .S_AXI_RRESP(rr),
    .PFI_IN(pfi_w), .SIL_IN(sil), .INT_SIG(isig),
    .START_PIN_O(st_o), .START_PIN_OE(st_oe), .SAMP_PIN_O(sp_o), .SAMP_PIN_OE(sp_oe),
    .UPDATE(upd)
  );

  aot_src_model u_aot_src_model (.CORE_CLK(clk), .PFI_IN(programmable_function_line), .SIL_IN(sil), .INT_SIG(isig));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic results;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  task automatic tmo;
    fail_count++;
    $display("mismatch wait expected done seen timeout");
    results();
  endtask : tmo

  // Bready and rready stay high, so the answer edge is the handshake
  task automatic wreg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr === 1'b1) awv <= 1'b0;
      if (w_rdy === 1'b1) wv <= 1'b0;
      if (n > 50) tmo();
    end while (bv !== 1'b1);
    chk("bresp", {30'h0, er}, {30'h0, br});
  endtask : wreg

  task automatic rreg(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = RESP_OKAY);
    int n;
    n = 0;
    ara <= a;
    arv <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr === 1'b1) arv <= 1'b0;
      if (n > 50) tmo();
    end while (rv !== 1'b1);
    d = rd;
    chk("rresp", {30'h0, er}, {30'h0, rr});
  endtask : rreg

  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                      input logic [31:0] m = 32'hFFFF_FFFF);
    logic [31:0] d;
    rreg(a, d);
    chk(nm, e, d & m);
  endtask : rchk

  task automatic wait_upd(input int n, input int lim);
    int k;
    k = 0;
    while (upd_cnt < n) begin
      @(posedge clk);
      k++;
      if (k > lim) tmo();
    end
  endtask : wait_upd

  task automatic clr;
    clr_req <= 1'b1;
    @(posedge clk);
    clr_req <= 1'b0;
  endtask : clr

  initial begin
    logic [31:0] d;
    int t0;
    int n0;
    cfg = '0;
    repeat (5) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    chk("start_oe", 32'h0, {31'h0, st_oe});
    chk("samp_oe", 32'h0, {31'h0, sp_oe});
    rchk("div", ADDR_DIV, DIV_RST);
    rchk("delay", ADDR_DELAY, 32'h2);
    rchk("cfg", ADDR_CFG, 32'h0);
    rchk("status", ADDR_STATUS, 32'h0);
    rreg(8'h1C, d, RESP_SLVERR);
    chk("unmapped", 32'h0, d);
    wreg(8'h1C, 32'hFFFF_FFFF, RESP_SLVERR);
    // Internal clock, finite run of three
    wreg(ADDR_DIV, 32'h4);
    wreg(ADDR_COUNT, 32'h3);
    wreg(ADDR_CTRL, 32'h9);
    wreg(ADDR_CTRL, 32'hA);
    t0 = cyc;
    wait_upd(3, 200);
    repeat (40) @(posedge clk);
    chk("upd_cnt", 32'd3, upd_cnt);
    chk("gap", 32'(4 * (CORE_HZ / FAST_TB_HZ)), gap);
    chk("first", 32'h1, 32'((tf - t0) inside {[6:11]}));
    chk("pin_w", 32'(3 * PULSE_CYC), spw);
    rchk("status", ADDR_STATUS, 32'h04, 32'h07);
    rchk("done", ADDR_DONE, 32'h3);
    // External sample clock, edges before arming
    clr();
    cfg.samp_ext = 1'b1;
    cfg.samp_sel = 5'h03;
    wreg(ADDR_CFG, 32'(cfg));
    wreg(ADDR_CTRL, 32'h40);
    chk("samp_oe", 32'h1, {31'h0, sp_oe});
    u_aot_src_model.pulse(3, 2);
    u_aot_src_model.pulse(3, 2);
    repeat (20) @(posedge clk);
    chk("ignored", 32'h0, upd_cnt);
    wreg(ADDR_CTRL, 32'h41);
    wreg(ADDR_CTRL, 32'h42);
    for (int k = 1; k <= 3; k++) begin
      u_aot_src_model.pulse(3, 2);
      wait_upd(k, 30);
    end
    repeat (10) @(posedge clk);
    chk("ext_w", 32'(3 * PULSE_CYC), spw);
    // Pause on line 0 at each level
    for (int p = 0; p < 2; p++) begin
      u_aot_src_model.hold(10, p[0]);
      cfg.pause_en = 1'b1;
      cfg.pause_sel = 5'h0A;
      cfg.pause_pol = p[0];
      wreg(ADDR_CFG, 32'(cfg));
      n0 = upd_cnt;
      u_aot_src_model.pulse(3, 2);
      repeat (20) @(posedge clk);
      chk("paused", 32'(n0), upd_cnt);
      rchk("status", ADDR_STATUS, 32'h0B, 32'h0F);
      u_aot_src_model.hold(10, ~p[0]);
      u_aot_src_model.pulse(3, 2);
      wait_upd(n0 + 1, 30);
    end
    // Software stop, later edges ignored
    wreg(ADDR_CTRL, 32'h44);
    rchk("status", ADDR_STATUS, 32'h0, 32'h3);
    n0 = upd_cnt;
    u_aot_src_model.pulse(3, 2);
    repeat (20) @(posedge clk);
    chk("stopped", 32'(n0), upd_cnt);
    // Hardware start from internal signal 0
    cfg = '0;
    cfg.start_en = 1'b1;
    cfg.start_sel = 5'd17;
    wreg(ADDR_CFG, 32'(cfg));
    clr();
    wreg(ADDR_CTRL, 32'h21);
    chk("start_oe", 32'h1, {31'h0, st_oe});
    wreg(ADDR_CTRL, 32'h22);
    rchk("status", ADDR_STATUS, 32'h1, 32'h3);
    u_aot_src_model.pulse(18, 1);
    repeat (10) @(posedge clk);
    rchk("status", ADDR_STATUS, 32'h2, 32'h2);
    chk("start_w", 32'(PULSE_CYC), stw);
    wreg(ADDR_CTRL, 32'h24);
    // Slow timebase, trade: 2000 cycles per sample
    cfg = '0;
    cfg.tb_slow = 1'b1;
    wreg(ADDR_CFG, 32'(cfg));
    wreg(ADDR_DIV, 32'h2);
    wreg(ADDR_COUNT, 32'h2);
    wreg(ADDR_CTRL, 32'h9);
    clr();
    wreg(ADDR_CTRL, 32'hA);
    wait_upd(2, 5000);
    chk("slow_gap", 32'(2 * (FAST_TB_HZ / SLOW_TB_HZ) * (CORE_HZ / FAST_TB_HZ)), gap);
    // Root from line 7, then external timebase on falling edges; edges lost while frozen
    wreg(ADDR_DIV, 32'h1);
    wreg(ADDR_DELAY, 32'h1);
    for (int v = 0; v < 2; v++) begin
      cfg = '0;
      cfg.tb_ext = v[0];
      cfg.tb_edge = 1'b1;
      cfg.tb_sel = 5'h02;
      wreg(ADDR_CFG, 32'(cfg));
      wreg(ADDR_CTRL, v ? 32'h9 : 32'h19);
      clr();
      wreg(ADDR_CTRL, v ? 32'hA : 32'h1A);
      repeat (60) @(posedge clk);
      chk("tb_idle", 32'h0, upd_cnt);
      ce <= 1'b0;
      u_aot_src_model.pulse(v ? 2 : 17, 2);
      repeat (4) @(posedge clk);
      ce <= 1'b1;
      chk("frozen", 32'h0, upd_cnt);
      for (int k = 1; k <= 2; k++) begin
        u_aot_src_model.pulse(v ? 2 : 17, 2);
        wait_upd(k, 30);
      end
      rchk("status", ADDR_STATUS, 32'h04, 32'h07);
    end
    results();
  end
endmodule : test_aot_engine
`default_nettype wire
